// ### core/cbpm_pkg.sv
// Package: register map, field layout and encodings of the context bank perf/remap block
`default_nettype none
package cbpm_pkg;
  localparam int unsigned NUM_SLOTS = 32;
  localparam logic [11:0] OFF_EVCNT_BASE = 12'h000;
  localparam logic [11:0] OFF_EVTYPE_BASE = 12'h400;
  localparam logic [11:0] OFF_IRQEN_SET = 12'hC40;
  localparam logic [11:0] OFF_IRQEN_CLR = 12'hC60;
  localparam logic [11:0] OFF_OVF_CLR = 12'hC80;
  localparam logic [11:0] OFF_OVF_SET = 12'hCC0;
  localparam logic [11:0] OFF_PERF_CTRL = 12'hE04;
  localparam logic [11:0] OFF_REMAP = 12'hF00;
  localparam logic [11:0] OFF_BANK_CFG = 12'hF40;
  // Perf control fields
  localparam int unsigned CTRL_EN_BIT = 0;
  localparam int unsigned CTRL_RST_CNT_BIT = 1;
  localparam int unsigned CTRL_WMASK_W = 2;
  localparam int unsigned CTRL_N_LSB = 11;
  // Bank config fields: group exposed, short-descriptor format
  localparam int unsigned CFG_GROUP_BIT = 0;
  localparam int unsigned CFG_SHORT_BIT = 1;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] REMAP_RESET = 32'h0000_0000;
  localparam logic [31:0] EVTYPE_WMASK = 32'h0000_FFFF;
  localparam int unsigned TR_FIELD_W = 2;
  localparam int unsigned TR_FIELDS = 8;
  localparam logic [1:0] TR_STRONG = 2'h0;
  localparam logic [1:0] TR_DEVICE = 2'h1;
  localparam logic [1:0] TR_NORMAL = 2'h2;
  localparam logic [1:0] TR_RSVD = 2'h3;
  typedef enum logic [1:0] {
    CBPM_MT_STRONG,
    CBPM_MT_DEVICE,
    CBPM_MT_NORMAL,
    CBPM_MT_RSVD
  } cbpm_memtype_e;
endpackage : cbpm_pkg
`default_nettype wire

// ### core/cbpm_slot_mem.sv
// Small register-output memory for event type slots
`default_nettype none
module cbpm_slot_mem #(
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = 5
) (
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [AW-1:0] waddr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [AW-1:0] raddr_i,
  output logic [31:0] rdata_o
);
  logic [31:0] mem_q [DEPTH];

  // Contents unreset on purpose: slot values have no defined reset
  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_q[raddr_i];
  end
endmodule : cbpm_slot_mem
`default_nettype wire

// ### core/cbpm_remap_dec.sv
// Registered attribute-index lookup through the remap register
`default_nettype none
module cbpm_remap_dec (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [15:0] remap_i,
  input wire logic short_fmt_i,
  input wire logic type_extension_bit0_i,
  input wire logic cacheable_i,
  input wire logic bufferable_i,
  output logic [1:0] mem_type_o,
  output logic remap_valid_o,
  output logic impl_index_o
);
  logic [2:0] idx;
  logic [1:0] field;

  always_comb begin
    idx = {type_extension_bit0_i, cacheable_i, bufferable_i};
    field = remap_i[idx*cbpm_pkg::TR_FIELD_W +: cbpm_pkg::TR_FIELD_W];
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      mem_type_o <= cbpm_pkg::TR_STRONG;
      remap_valid_o <= 1'b0;
      impl_index_o <= 1'b0;
    end else begin
      // Encodings pass through: 00 strong, 01 device, 10 normal, 11 reserved
      mem_type_o <= field;
      remap_valid_o <= short_fmt_i;
      impl_index_o <= (idx == 3'h6);
    end
  end
endmodule : cbpm_remap_dec
`default_nettype wire

// ### core/cbpm_bank.sv
// Context bank perf monitor window and primary region remap register, APB slave
//
// The implementer's own choices: the register offsets and register access over APB.
`default_nettype none
module cbpm_bank #(
  parameter int unsigned NUM_COUNTERS = 4,
  parameter int unsigned NUM_TYPES = 4,
  parameter int unsigned CNT_W = 32
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic [NUM_COUNTERS-1:0] event_i,
  input wire logic type_extension_bit0_i,
  input wire logic cacheable_i,
  input wire logic bufferable_i,
  output logic [1:0] mem_type_o,
  output logic remap_valid_o,
  output logic impl_index_o,
  output logic [NUM_COUNTERS-1:0] counter_irq_o
);
  typedef struct packed {
    logic [31:0] cfg;
    logic [31:0] ctrl;
    logic [31:0] remap;
    logic [NUM_COUNTERS-1:0] irq_en;
    logic [NUM_COUNTERS-1:0] ovf;
    logic [NUM_COUNTERS-1:0] irq;
    logic [NUM_COUNTERS-1:0][CNT_W-1:0] cnt;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } cbpm_state_s;

  cbpm_state_s s_q, s_d;

  logic group;
  logic access;
  logic setup;
  logic [11:0] a;
  logic [4:0] slot;
  logic in_cnt, in_type;
  logic type_we;
  logic [31:0] type_rdata;
  logic [31:0] rd;
  logic hit;
  logic [NUM_COUNTERS-1:0] wset;
  logic [NUM_COUNTERS-1:0] ovf_ev;

  assign group = s_q.cfg[cbpm_pkg::CFG_GROUP_BIT];
  assign a = paddr_i;
  assign slot = a[6:2];
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i && s_q.ready;
  assign in_cnt = (a[11:7] == cbpm_pkg::OFF_EVCNT_BASE[11:7]) && (a[1:0] == 2'h0);
  assign in_type = (a[11:7] == cbpm_pkg::OFF_EVTYPE_BASE[11:7]) && (a[1:0] == 2'h0);
  assign wset = pwdata_i[NUM_COUNTERS-1:0];
  // Type writes dropped for unexposed group and slots past the type count
  assign type_we = access && pwrite_i && in_type && group
    && ({27'h0, slot} < NUM_TYPES);

  cbpm_slot_mem #(
    .DEPTH(cbpm_pkg::NUM_SLOTS),
    .AW(5)
  ) u_types (
    .clk_i(clk_i),
    .we_i(type_we),
    .waddr_i(slot),
    .wdata_i(pwdata_i & cbpm_pkg::EVTYPE_WMASK),
    .raddr_i(slot),
    .rdata_o(type_rdata)
  );

  cbpm_remap_dec u_dec (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .remap_i(s_q.remap[15:0]),
    .short_fmt_i(s_q.cfg[cbpm_pkg::CFG_SHORT_BIT]),
    .type_extension_bit0_i(type_extension_bit0_i),
    .cacheable_i(cacheable_i),
    .bufferable_i(bufferable_i),
    .mem_type_o(mem_type_o),
    .remap_valid_o(remap_valid_o),
    .impl_index_o(impl_index_o)
  );

  // Read mux; unexposed or out-of-range views read zero as the unknown value
  always_comb begin
    rd = 32'h0000_0000;
    hit = 1'b1;
    if (in_cnt) begin
      if (group && ({27'h0, slot} < NUM_COUNTERS)) begin
        rd = 32'(s_q.cnt[slot[$clog2(NUM_COUNTERS)-1:0]]);
      end
    end else if (in_type) begin
      hit = 1'b1;
    end else begin
      case (a)
        cbpm_pkg::OFF_PERF_CTRL: begin
          if (group) begin
            rd = s_q.ctrl;
            rd[cbpm_pkg::CTRL_RST_CNT_BIT] = 1'b0;
            rd[cbpm_pkg::CTRL_N_LSB +: 5] = 5'(NUM_COUNTERS);
          end
        end
        cbpm_pkg::OFF_IRQEN_SET, cbpm_pkg::OFF_IRQEN_CLR: begin
          if (group) begin
            rd = 32'(s_q.irq_en);
          end
        end
        cbpm_pkg::OFF_OVF_SET, cbpm_pkg::OFF_OVF_CLR: begin
          if (group) begin
            rd = 32'(s_q.ovf);
          end
        end
        cbpm_pkg::OFF_REMAP: rd = s_q.remap;
        cbpm_pkg::OFF_BANK_CFG: rd = s_q.cfg;
        default: hit = 1'b0;
      endcase
    end
  end

  // Counting and overflow events
  always_comb begin
    ovf_ev = '0;
    for (int i = 0; i < NUM_COUNTERS; i++) begin
      if (group && s_q.ctrl[cbpm_pkg::CTRL_EN_BIT] && event_i[i]
          && (s_q.cnt[i] == {CNT_W{1'b1}})) begin
        ovf_ev[i] = 1'b1;
      end
    end
  end

  always_comb begin
    s_d = s_q;
    s_d.ready = 1'b0;
    // Memory read data arrives one cycle after setup, so reply then
    // Error decided in setup so the flag leaves a register with ready
    s_d.err = setup && !hit;
    if (setup) begin
      s_d.ready = 1'b1;
    end
    if (group && s_q.ctrl[cbpm_pkg::CTRL_EN_BIT]) begin
      for (int i = 0; i < NUM_COUNTERS; i++) begin
        if (event_i[i]) begin
          s_d.cnt[i] = s_q.cnt[i] + CNT_W'(1);
        end
      end
    end
    if (access && pwrite_i) begin
      if (in_cnt && group && ({27'h0, slot} < NUM_COUNTERS)) begin
        s_d.cnt[slot[$clog2(NUM_COUNTERS)-1:0]] = CNT_W'(pwdata_i);
      end
      case (a)
        cbpm_pkg::OFF_PERF_CTRL: begin
          if (group) begin
            s_d.ctrl = {30'h0, pwdata_i[cbpm_pkg::CTRL_WMASK_W-1:0]};
            if (pwdata_i[cbpm_pkg::CTRL_RST_CNT_BIT]) begin
              s_d.cnt = '0;
            end
          end
        end
        cbpm_pkg::OFF_IRQEN_SET: if (group) s_d.irq_en = s_q.irq_en | wset;
        cbpm_pkg::OFF_IRQEN_CLR: if (group) s_d.irq_en = s_q.irq_en & ~wset;
        cbpm_pkg::OFF_OVF_SET: if (group) s_d.ovf = s_q.ovf | wset;
        cbpm_pkg::OFF_OVF_CLR: if (group) s_d.ovf = s_q.ovf & ~wset;
        cbpm_pkg::OFF_REMAP: s_d.remap = pwdata_i;
        cbpm_pkg::OFF_BANK_CFG: s_d.cfg = {30'h0, pwdata_i[1:0]};
        default: s_d.cfg = s_d.cfg;
      endcase
    end
    // Hardware overflow wins over a same-cycle clear
    s_d.ovf = s_d.ovf | ovf_ev;
    s_d.irq = s_d.ovf & s_d.irq_en;
    s_d.rdata = in_type ? 32'h0 : rd;
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      s_q <= '0;
      s_q.cfg <= cbpm_pkg::CFG_RESET;
      s_q.ctrl <= cbpm_pkg::CTRL_RESET;
      s_q.remap <= cbpm_pkg::REMAP_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  // Type slot data comes from the memory register; others from state
  always_comb begin
    prdata_o = 32'h0;
    if (in_type && group && ({27'h0, slot} < NUM_TYPES)) begin
      prdata_o = type_rdata;
    end else if (!in_type) begin
      prdata_o = s_q.rdata;
    end
  end
  assign pready_o = s_q.ready;
  assign pslverr_o = s_q.err;
  assign counter_irq_o = s_q.irq;
endmodule : cbpm_bank
`default_nettype wire

// ### tb/cbpm_checker.sv
// Port-level assertions for the context bank perf/remap block
`default_nettype none
module cbpm_checker (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire logic type_extension_bit0_i,
  input wire logic cacheable_i,
  input wire logic bufferable_i,
  input wire logic [1:0] mem_type_o,
  input wire logic remap_valid_o,
  input wire logic impl_index_o
);
  logic [31:0] remap_q;
  logic [31:0] cfg_q;
  logic [1:0] mt_q;
  logic six_q;
  logic acc;
  logic wr;
  logic mapped;
  logic perf;
  logic [2:0] idx;
  assign acc = psel_i && penable_i && pready_o;
  assign wr = acc && pwrite_i;
  assign idx = {type_extension_bit0_i, cacheable_i, bufferable_i};
  assign perf = paddr_i < 12'h080 || (paddr_i >= 12'h400 && paddr_i < 12'h480)
    || paddr_i inside {12'hC40, 12'hC60, 12'hC80, 12'hCC0, 12'hE04};
  assign mapped = perf || paddr_i inside {12'hF00, 12'hF40};
  // Shadow copies let the lookup be predicted without seeing the body
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      remap_q <= 32'h0;
      cfg_q <= 32'h0;
      mt_q <= 2'h0;
      six_q <= 1'b0;
    end else begin
      if (wr && paddr_i == 12'hF00) remap_q <= pwdata_i;
      if (wr && paddr_i == 12'hF40) cfg_q <= pwdata_i;
      mt_q <= remap_q[2*idx +: 2];
      six_q <= idx == 3'h6;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_idle_no_ready: assert property (!psel_i |=> !pready_o)
    else $error("ready without request");
  a_err_unmapped: assert property (acc && paddr_i[1:0] == 2'h0 |-> pslverr_o == !mapped)
    else $error("error flag wrong for address");
  a_remap_readback: assert property (acc && !pwrite_i && paddr_i == 12'hF00 |-> prdata_o == remap_q)
    else $error("remap readback wrong");
  a_nogroup_raz: assert property (acc && !pwrite_i && perf && !cfg_q[0] |-> prdata_o == 32'h0)
    else $error("perf view not zero without group");
  a_mem_type_map: assert property (mem_type_o == mt_q)
    else $error("memory type lookup wrong");
  a_impl_index: assert property (impl_index_o == six_q)
    else $error("index six flag wrong");
  a_fmt_valid: assert property (wr && paddr_i == 12'hF40 |-> ##2 remap_valid_o == cfg_q[1])
    else $error("remap valid not following format");
  cover property (wr && paddr_i == 12'hF00);
  cover property (impl_index_o);
  cover property (pslverr_o && pready_o);
endmodule : cbpm_checker
bind cbpm_bank cbpm_checker u_chk (.*);
`default_nettype wire

// ### tb/tb_top.sv
// Self-checking bench for the context bank perf/remap block
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NC = 4;
  localparam logic [31:0] RV = 32'hABCD_91A4;
  logic clk_i = 0, rstn_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, prdata_o, rd;
  logic pready_o, pslverr_o, er, remap_valid_o, impl_index_o;
  logic [NC-1:0] event_i = 0, counter_irq_o;
  logic type_extension_bit0_i = 0, cacheable_i = 0, bufferable_i = 0;
  logic [1:0] mem_type_o;
  int error_cnt = 0;
  int tests_run = 0;
  always #20 clk_i = ~clk_i;
  cbpm_bank #(.NUM_COUNTERS(NC), .NUM_TYPES(NC)) DUT (.*);
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", n, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1;
    n = 0;
    // Look mid-cycle so the answer is settled, not racing its own edge
    do begin
      @(negedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    if (pready_o !== 1'b1) begin
      error_cnt++;
      $display("unexpected pready exp 1 got %b", pready_o);
      report_and_stop();
    end
    rd = prdata_o;
    er = pslverr_o;
    @(posedge clk_i);
    psel_i <= 0;
    penable_i <= 0;
  endtask : apb
  task automatic rc(input string n, input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 0);
    chk(n, e, rd);
  endtask : rc
  task automatic t_nogroup();
    logic [11:0] a[6] = '{12'hE04, 12'h000, 12'h400, 12'hC40, 12'hCC0, 12'h07C};
    apb(1, 12'hF40, 32'h0);
    foreach (a[i]) begin
      apb(1, a[i], 32'hFFFF_FFFF);
      rc("nogroup view", a[i], 32'h0);
    end
    apb(0, 12'h800, 0);
    chk("unmapped err", 32'h1, 32'(er));
  endtask : t_nogroup
  task automatic t_group();
    apb(1, 12'hF40, 32'h1);
    rc("counter kept", 12'h000, 32'h0);
    rc("control kept", 12'hE04, 32'(NC) << 11);
    apb(1, 12'h404, 32'h0000_1234);
    rc("type slot 1", 12'h404, 32'h0000_1234);
    apb(1, 12'h400, 32'h0000_00A5);
    apb(1, 12'hF40, 32'h0);
    apb(1, 12'h400, 32'h0000_5A5A);
    apb(1, 12'hF40, 32'h1);
    rc("type ignored", 12'h400, 32'h0000_00A5);
    apb(1, 12'h410, 32'h1);
    rc("type beyond", 12'h410, 32'h0);
    apb(1, 12'h004, 32'h55);
    rc("counter 1", 12'h004, 32'h55);
    apb(1, 12'h010, 32'h7);
    rc("counter beyond", 12'h010, 32'h0);
    apb(1, 12'hC40, 32'h5);
    rc("irq clear view", 12'hC60, 32'h5);
    apb(1, 12'hC60, 32'h1);
    rc("irq set view", 12'hC40, 32'h4);
    apb(1, 12'hCC0, 32'h3);
    apb(1, 12'hC80, 32'h2);
    rc("overflow", 12'hCC0, 32'h1);
    apb(1, 12'hC80, 32'h1);
    // Counter 2 at all-ones wraps on one event
    apb(1, 12'h008, 32'hFFFF_FFFF);
    apb(1, 12'hE04, 32'h1);
    rc("control", 12'hE04, (32'(NC) << 11) | 32'h1);
    @(posedge clk_i) event_i <= 4'h4;
    @(posedge clk_i) event_i <= 4'h0;
    repeat (2) @(posedge clk_i);
    rc("wrapped counter", 12'h008, 32'h0);
    rc("wrap overflow", 12'hCC0, 32'h4);
    chk("counter irq", 32'h4, 32'(counter_irq_o));
    apb(1, 12'hE04, 32'h3);
    rc("counters reset", 12'h004, 32'h0);
  endtask : t_group
  task automatic t_remap();
    apb(1, 12'hF40, 32'h3);
    apb(1, 12'hF00, RV);
    rc("remap", 12'hF00, RV);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk_i);
      {type_extension_bit0_i, cacheable_i, bufferable_i} <= 3'(i);
      repeat (2) @(posedge clk_i);
      chk("mem type", 32'(RV[2*i +: 2]), 32'(mem_type_o));
      chk("index six", 32'(i == 6), 32'(impl_index_o));
    end
    chk("remap valid", 32'h1, 32'(remap_valid_o));
    apb(1, 12'hF40, 32'h1);
    repeat (2) @(posedge clk_i);
    chk("remap invalid", 32'h0, 32'(remap_valid_o));
  endtask : t_remap
  initial begin
    repeat (2) @(posedge clk_i);
    rstn_i <= 1;
    t_nogroup();
    t_group();
    t_remap();
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
